// ---- hw/gst_pkg.sv ----
package gst_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CNT_LO = 8'h04;
  localparam logic [7:0] OFF_CNT_HI = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_PINS = 8'h10;

  // control field positions
  localparam int CTRL_TIMER_ON = 0;
  localparam int CTRL_CLK_SRC = 1;
  localparam int CTRL_SYNC_DIS = 2;
  localparam int CTRL_OSC_EN = 3;
  localparam int CTRL_PRE_LO = 4;
  localparam int CTRL_PRE_HI = 5;

  // status and pin view field positions
  localparam int STAT_OVF = 0;
  localparam int PIN_DIR_A = 0;
  localparam int PIN_DIR_B = 1;
  localparam int PIN_DAT_A = 2;
  localparam int PIN_DAT_B = 3;

  // reset values and the count maximum
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [1:0] PIN_DIR_RST = 2'h3;
  localparam logic [1:0] PIN_DAT_RST = 2'h0;

  // instruction clock is a quarter of the system clock
  localparam logic [1:0] INSTR_LAST = 2'h3;

  // prescale select codes
  typedef enum logic [1:0] {
    GST_DIV1 = 2'h0,
    GST_DIV2 = 2'h1,
    GST_DIV4 = 2'h2,
    GST_DIV8 = 2'h3
  } gst_div_t;

endpackage : gst_pkg

// ---- hw/gst_pre_if.sv ----
`timescale 1ns/1ps
interface gst_pre_if;
  logic tick;
  logic clear;
  gst_pkg::gst_div_t sel;
  logic out;

  modport ctl (output tick, output clear, output sel, input out);
  modport pre (input tick, input clear, input sel, output out);
endinterface : gst_pre_if

// ---- hw/gst_pin_sync.sv ----
`timescale 1ns/1ps
module gst_pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] levelOut
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } gst_sync_t;

  gst_sync_t st_r;
  gst_sync_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pinIn;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // level changes only once stages two and three agree
    for (int i = 0; i < WIDTH; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.lvl[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign levelOut = st_r.lvl;

endmodule : gst_pin_sync

// ---- hw/gst_prescaler.sv ----
`timescale 1ns/1ps
module gst_prescaler (
  input wire logic mclk,
  input wire logic rst_n,
  gst_pre_if.pre bus
);

  typedef struct packed {
    logic [2:0] cnt;
  } gst_pre_t;

  gst_pre_t st_r;
  gst_pre_t st_nxt;
  logic [2:0] mask;

  always_comb begin
    case (bus.sel)
      gst_pkg::GST_DIV1: mask = 3'h0;
      gst_pkg::GST_DIV2: mask = 3'h1;
      gst_pkg::GST_DIV4: mask = 3'h3;
      gst_pkg::GST_DIV8: mask = 3'h7;
      default: mask = 3'h0;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    if (bus.clear) begin
      st_nxt.cnt = 3'h0;
    end else if (bus.tick) begin
      st_nxt.cnt = (st_r.cnt & mask) == mask ? 3'h0 : st_r.cnt + 3'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // one pulse per 1, 2, 4 or 8 ticks
  assign bus.out = bus.tick && !bus.clear && ((st_r.cnt & mask) == mask);

endmodule : gst_prescaler

// ---- hw/gst_timer.sv ----
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
module gst_timer (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic extCountClockPin,
  input wire logic xtalInputPin,
  input wire logic internalOscillator,
  input wire logic sysOscLpMode,
  input wire logic sleepMode,
  output logic overflowFlag,
  output logic wakeReq,
  output logic lpOscRun
);

  typedef struct packed {
    logic timerOn;
    logic clkSrc;
    logic syncDis;
    logic oscEn;
    logic [1:0] preSel;
    logic [1:0] pinDir;
    logic [1:0] pinDat;
    logic [15:0] count;
    logic ovf;
    logic armed;
    logic extPrev;
    logic [1:0] instrDiv;
    logic preLvl;
    logic ps1;
    logic ps2;
    logic ps3;
    logic ready;
    logic err;
    logic [31:0] rdata;
    logic wake;
    logic oscRun;
  } gst_state_t;

  gst_state_t st_r;
  gst_state_t st_nxt;

  gst_pre_if preBus ();

  logic [1:0] pinLvl;
  logic extLvl;
  logic accessWr;
  logic setupRd;
  logic wrCtrl;
  logic wrLo;
  logic wrHi;
  logic wrStat;
  logic wrPins;
  logic cntWrite;
  logic instrTick;
  logic extRise;
  logic syncRise;
  logic inc;
  logic rollover;
  // helpers for arming, flag, wake and oscillator gating
  logic extFall;
  logic oscAllowed;
  logic flagClr;
  logic asyncMode;
  logic wakeSet;
  logic cntTop;

  gst_pin_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pinIn({xtalInputPin, extCountClockPin}),
    .levelOut(pinLvl)
  );

  gst_prescaler u_prescaler (
    .mclk(mclk),
    .rst_n(rst_n),
    .bus(preBus.pre)
  );

  function automatic logic isAddr(input logic [7:0] a, input logic [7:0] off);
    isAddr = (a == off);
  endfunction : isAddr

  // one byte of the live count, nothing latched
  function automatic logic [7:0] cntByte(input logic [15:0] c, input logic hi);
    cntByte = hi ? c[15:8] : c[7:0];
  endfunction : cntByte

  assign accessWr = psel && penable && pwrite && st_r.ready;
  assign setupRd = psel && !penable;
  assign wrCtrl = accessWr && isAddr(paddr, gst_pkg::OFF_CTRL);
  assign wrLo = accessWr && isAddr(paddr, gst_pkg::OFF_CNT_LO);
  assign wrHi = accessWr && isAddr(paddr, gst_pkg::OFF_CNT_HI);
  assign wrStat = accessWr && isAddr(paddr, gst_pkg::OFF_STATUS);
  assign wrPins = accessWr && isAddr(paddr, gst_pkg::OFF_PINS);
  assign cntWrite = wrLo || wrHi;

  // oscillator output replaces the pin as external source
  assign extLvl = st_r.oscRun ? pinLvl[1] : pinLvl[0];

  // instruction clock is a quarter of mclk, frozen in sleep
  assign instrTick = (st_r.instrDiv == gst_pkg::INSTR_LAST) && !sleepMode;

  // rising edge of the external source
  // only once a falling edge has armed the counter
  assign extRise = extLvl && !st_r.extPrev && st_r.armed;

  // falling edge of the external source, the only thing that arms
  // a low level alone must not arm: re-enabling with the pin low waits for a fall
  assign extFall = !extLvl && st_r.extPrev;

  // each toggle of the re-synchronised level is one prescaled edge
  assign syncRise = st_r.ps2 != st_r.ps3;

  always_comb begin
    preBus.tick = 1'b0;
    if (st_r.timerOn) begin
      preBus.tick = st_r.clkSrc ? extRise : instrTick;
    end
  end
  assign preBus.clear = cntWrite;
  assign preBus.sel = gst_pkg::gst_div_t'(st_r.preSel);

  // unsynchronised count takes the prescaler pulse straight
  // only the asynchronous external path runs during sleep
  always_comb begin
    if (!st_r.timerOn) begin
      inc = 1'b0;
    end else if (!st_r.clkSrc) begin
      inc = preBus.out;
    end else if (st_r.syncDis) begin
      inc = preBus.out;
    end else begin
      inc = syncRise && !sleepMode;
    end
  end

  assign cntTop = st_r.count == gst_pkg::CNT_MAX;
  assign rollover = inc && cntTop && !cntWrite;

  // software writes one to the flag bit
  assign flagClr = wrStat && pwdata[gst_pkg::STAT_OVF];

  // external unsynchronised counting is the only path alive in sleep
  assign asyncMode = st_r.clkSrc && st_r.syncDis;
  assign wakeSet = rollover && sleepMode && asyncMode;

  // shared oscillator only with internal or low-power system clock
  assign oscAllowed = internalOscillator || sysOscLpMode;

  always_comb begin
    st_nxt = st_r;
    st_nxt.instrDiv = st_r.instrDiv + 2'h1;
    st_nxt.extPrev = extLvl;

    // mode switches change path only, no compensation
    // prescaled external level toggles then passes three stages
    if (st_r.clkSrc && !st_r.syncDis && preBus.out) begin
      st_nxt.preLvl = !st_r.preLvl;
    end
    st_nxt.ps1 = st_r.preLvl;
    st_nxt.ps2 = st_r.ps1;
    st_nxt.ps3 = st_r.ps2;

    // disarm on stop or count write, arm on falling edge
    if (!st_r.timerOn || cntWrite) begin
      st_nxt.armed = 1'b0;
    end else if (extFall) begin
      st_nxt.armed = 1'b1;
    end

    if (inc) begin
      st_nxt.count = st_r.count + 16'h0001;
    end
    // byte writes load directly and win over increment
    if (wrLo) begin
      st_nxt.count[7:0] = pwdata[7:0];
    end
    if (wrHi) begin
      st_nxt.count[15:8] = pwdata[7:0];
    end

    // write one clears, a new rollover wins
    if (flagClr) begin
      st_nxt.ovf = 1'b0;
    end
    if (rollover) begin
      st_nxt.ovf = 1'b1;
    end

    // wake request on asynchronous overflow in sleep
    st_nxt.wake = wakeSet;

    if (wrCtrl) begin
      st_nxt.timerOn = pwdata[gst_pkg::CTRL_TIMER_ON];
      st_nxt.clkSrc = pwdata[gst_pkg::CTRL_CLK_SRC];
      st_nxt.syncDis = pwdata[gst_pkg::CTRL_SYNC_DIS];
      st_nxt.oscEn = pwdata[gst_pkg::CTRL_OSC_EN];
      st_nxt.preSel = pwdata[gst_pkg::CTRL_PRE_HI:gst_pkg::CTRL_PRE_LO];
    end
    if (wrPins) begin
      st_nxt.pinDir = {pwdata[gst_pkg::PIN_DIR_B], pwdata[gst_pkg::PIN_DIR_A]};
      st_nxt.pinDat = {pwdata[gst_pkg::PIN_DAT_B], pwdata[gst_pkg::PIN_DAT_A]};
    end

    // oscillator keeps running regardless of sleep
    // only with internal system clock or low-power crystal mode
    st_nxt.oscRun = st_r.oscEn && oscAllowed;

    // apb: no wait states, data sampled in the setup cycle
    st_nxt.ready = setupRd;
    st_nxt.err = 1'b0;
    st_nxt.rdata = 32'h0000_0000;
    if (setupRd) begin
      case (paddr)
        gst_pkg::OFF_CTRL: begin
          st_nxt.rdata[gst_pkg::CTRL_TIMER_ON] = st_r.timerOn;
          st_nxt.rdata[gst_pkg::CTRL_CLK_SRC] = st_r.clkSrc;
          st_nxt.rdata[gst_pkg::CTRL_SYNC_DIS] = st_r.syncDis;
          st_nxt.rdata[gst_pkg::CTRL_OSC_EN] = st_r.oscEn;
          st_nxt.rdata[gst_pkg::CTRL_PRE_HI:gst_pkg::CTRL_PRE_LO] = st_r.preSel;
        end
        gst_pkg::OFF_CNT_LO: st_nxt.rdata[7:0] = cntByte(st_r.count, 1'h0);
        gst_pkg::OFF_CNT_HI: st_nxt.rdata[7:0] = cntByte(st_r.count, 1'h1);
        gst_pkg::OFF_STATUS: st_nxt.rdata[gst_pkg::STAT_OVF] = st_r.ovf;
        gst_pkg::OFF_PINS: begin
          // forced pin view while oscillator enabled
          if (st_r.oscEn) begin
            st_nxt.rdata[gst_pkg::PIN_DIR_A] = 1'b1;
            st_nxt.rdata[gst_pkg::PIN_DIR_B] = 1'b1;
          end else begin
            st_nxt.rdata[gst_pkg::PIN_DIR_A] = st_r.pinDir[0];
            st_nxt.rdata[gst_pkg::PIN_DIR_B] = st_r.pinDir[1];
            st_nxt.rdata[gst_pkg::PIN_DAT_A] = st_r.pinDat[0];
            st_nxt.rdata[gst_pkg::PIN_DAT_B] = st_r.pinDat[1];
          end
        end
        default: st_nxt.err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.count <= gst_pkg::CNT_RST;
      st_r.pinDir <= gst_pkg::PIN_DIR_RST;
      st_r.pinDat <= gst_pkg::PIN_DAT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.rdata;
  assign pready = st_r.ready;
  assign pslverr = st_r.err;
  assign overflowFlag = st_r.ovf;
  assign wakeReq = st_r.wake;
  assign lpOscRun = st_r.oscRun;

endmodule : gst_timer

// ---- testbench/gst_timer_props.sv ----
`timescale 1ns/1ps
module gst_timer_props (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic internalOscillator,
  input wire logic sysOscLpMode,
  input wire logic sleepMode,
  input wire logic overflowFlag,
  input wire logic wakeReq,
  input wire logic lpOscRun
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic mapped;
  assign mapped = paddr[1:0] == 2'h0 && paddr <= gst_pkg::OFF_PINS;
  a_ready_one_wait: assert property (psel && !penable |=> pready)
    else $error("pready not one cycle after setup");
  a_ready_in_access: assert property (pready |-> psel && penable && $past(psel && !penable))
    else $error("pready outside access phase");
  a_err_unmapped: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr wrong for address");
  a_rdata_quiet: assert property (!pready || pslverr |-> prdata == 32'h0)
    else $error("prdata not zero");
  a_osc_gated: assert property (lpOscRun |-> $past(internalOscillator || sysOscLpMode))
    else $error("oscillator runs without allowed clock");
  a_flag_clear: assert property ($fell(overflowFlag) |->
    $past(pready && pwrite && paddr == gst_pkg::OFF_STATUS && pwdata[0]))
    else $error("overflow flag cleared without write");
  a_wake_pulse: assert property (wakeReq |=> !wakeReq)
    else $error("wake request longer than a cycle");
  a_wake_sleep: assert property (wakeReq |-> $past(sleepMode))
    else $error("wake request while awake");
endmodule : gst_timer_props

bind gst_timer gst_timer_props i_gst_timer_props (.mclk(mclk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .internalOscillator(internalOscillator),
  .sysOscLpMode(sysOscLpMode), .sleepMode(sleepMode), .overflowFlag(overflowFlag),
  .wakeReq(wakeReq), .lpOscRun(lpOscRun));

// ---- testbench/gst_ext_clk_src.sv ----
`timescale 1ns/1ps
module gst_ext_clk_src #(
  parameter int HALF_NS = 730
) (
  output logic pin
);
  // idles high between bursts, no free-running clock
  initial pin = 1'h1;
  // each pulse falls before it rises
  task automatic burst(input int n);
    repeat (n) begin
      pin = 1'h0;
      #(HALF_NS);
      pin = 1'h1;
      #(HALF_NS);
    end
  endtask : burst
endmodule : gst_ext_clk_src

// ---- testbench/gst_timer_tb_top.sv ----
`timescale 1ns/1ps
module gst_timer_tb_top;
  typedef struct {
    logic wr;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] q;
    logic e;
  } gst_row_t;
  logic mclk = 1'h0;
  logic rst_n = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic extPin;
  logic internal_oscillator = 1'h1;
  logic lpMode = 1'h0;
  logic sleep = 1'h0;
  logic ovf;
  logic wake;
  logic oscRun;
  logic sawWake = 1'h0;
  logic lastErr;
  logic [31:0] rd;
  logic [7:0] held;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  gst_row_t rows[11] = '{
    '{1'h0, gst_pkg::OFF_CTRL, 32'h0, 32'h0, 1'h0},
    '{1'h0, gst_pkg::OFF_CNT_LO, 32'h0, 32'h0, 1'h0},
    '{1'h0, gst_pkg::OFF_PINS, 32'h0, 32'h3, 1'h0},
    '{1'h1, gst_pkg::OFF_CNT_LO, 32'h5A, 32'h0, 1'h0},
    '{1'h0, gst_pkg::OFF_CNT_LO, 32'h0, 32'h5A, 1'h0},
    '{1'h1, gst_pkg::OFF_CNT_HI, 32'hA5, 32'h0, 1'h0},
    '{1'h0, gst_pkg::OFF_CNT_HI, 32'h0, 32'hA5, 1'h0},
    '{1'h1, gst_pkg::OFF_CTRL, 32'h3E, 32'h0, 1'h0},
    '{1'h0, gst_pkg::OFF_CTRL, 32'h0, 32'h3E, 1'h0},
    '{1'h0, gst_pkg::OFF_PINS, 32'h0, 32'h3, 1'h0},
    '{1'h0, 8'h14, 32'h0, 32'h0, 1'h1}
  };
  gst_timer i_gst_timer (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .extCountClockPin(extPin), .xtalInputPin(extPin),
    .internalOscillator(internal_oscillator), .sysOscLpMode(lpMode), .sleepMode(sleep),
    .overflowFlag(ovf), .wakeReq(wake), .lpOscRun(oscRun));
  gst_ext_clk_src i_gst_ext_clk_src (.pin(extPin));
  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (wake === 1'h1) begin
      sawWake <= 1'h1;
    end
    if (cyc == 30000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do @(posedge mclk); while (pready !== 1'h1);
    rd = prdata;
    lastErr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge mclk);
  endtask : apb
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic near(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (!(got === exp || got === exp + 8'h1 || got === exp - 8'h1)) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : near
  task automatic pulses(input int n);
    i_gst_ext_clk_src.burst(n);
    repeat (12) @(posedge mclk);
  endtask : pulses
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'h1;
    @(posedge mclk);
    chk("outputs", 32'h0, {29'h0, ovf, wake, oscRun});
    // oscillator enabled while timer stays off
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) chk("rdata", rows[i].q, rd);
      chk("slverr", {31'h0, rows[i].e}, {31'h0, lastErr});
    end
    chk("oscRun", 32'h1, {31'h0, oscRun});
    internal_oscillator <= 1'h0;
    repeat (3) @(posedge mclk);
    chk("oscRun", 32'h0, {31'h0, oscRun});
    lpMode <= 1'h1;
    repeat (3) @(posedge mclk);
    chk("oscRun", 32'h1, {31'h0, oscRun});
    apb(1'h1, gst_pkg::OFF_CTRL, 32'h0);
    $display("register rows done");
    for (int k = 0; k < 4; k++) begin
      apb(1'h1, gst_pkg::OFF_CTRL, {26'h0, 2'(k), 4'h5});
      apb(1'h1, gst_pkg::OFF_CNT_LO, 32'h0);
      repeat ((4 << k) * 16 - 2) @(posedge mclk);
      apb(1'h0, gst_pkg::OFF_CNT_LO, 32'h0);
      near("prescale", 8'h10, rd[7:0]);
    end
    apb(1'h1, gst_pkg::OFF_CTRL, 32'h0);
    apb(1'h0, gst_pkg::OFF_CNT_LO, 32'h0);
    held = rd[7:0];
    repeat (40) @(posedge mclk);
    apb(1'h0, gst_pkg::OFF_CNT_LO, 32'h0);
    chk("held", {24'h0, held}, rd);
    $display("internal count done");
    apb(1'h1, gst_pkg::OFF_CNT_LO, 32'hFC);
    apb(1'h1, gst_pkg::OFF_CNT_HI, 32'hFF);
    apb(1'h1, gst_pkg::OFF_CTRL, 32'h1);
    repeat (30) @(posedge mclk);
    chk("ovf", 32'h1, {31'h0, ovf});
    apb(1'h0, gst_pkg::OFF_CNT_HI, 32'h0);
    chk("high", 32'h0, rd);
    apb(1'h1, gst_pkg::OFF_STATUS, 32'h1);
    chk("ovf", 32'h0, {31'h0, ovf});
    $display("rollover done");
    apb(1'h1, gst_pkg::OFF_CTRL, 32'h3);
    apb(1'h1, gst_pkg::OFF_CNT_LO, 32'h0);
    pulses(5);
    apb(1'h0, gst_pkg::OFF_CNT_LO, 32'h0);
    chk("sync", 32'h5, rd);
    apb(1'h1, gst_pkg::OFF_CTRL, 32'h17);
    apb(1'h1, gst_pkg::OFF_CNT_LO, 32'h0);
    pulses(6);
    apb(1'h0, gst_pkg::OFF_CNT_LO, 32'h0);
    chk("async", 32'h3, rd);
    $display("external count done");
    // oscillator as count source, same waveform on the crystal input
    apb(1'h1, gst_pkg::OFF_CTRL, 32'hF);
    apb(1'h1, gst_pkg::OFF_CNT_LO, 32'h0);
    pulses(4);
    apb(1'h0, gst_pkg::OFF_CNT_LO, 32'h0);
    chk("osc", 32'h4, rd);
    $display("oscillator count done");
    apb(1'h1, gst_pkg::OFF_CTRL, 32'h7);
    apb(1'h1, gst_pkg::OFF_CNT_LO, 32'hFE);
    apb(1'h1, gst_pkg::OFF_CNT_HI, 32'hFF);
    sleep <= 1'h1;
    pulses(3);
    sleep <= 1'h0;
    chk("wake", 32'h3, {30'h0, sawWake, ovf});
    $display("sleep wake done");
    rst_n <= 1'h0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'h1;
    @(posedge mclk);
    chk("rst outputs", 32'h0, {29'h0, ovf, wake, oscRun});
    apb(1'h0, gst_pkg::OFF_CNT_LO, 32'h0);
    chk("rst count", 32'h0, rd);
    apb(1'h0, gst_pkg::OFF_PINS, 32'h0);
    chk("rst pins", 32'h3, rd);
    $display("mid-run reset done");
    end_of_test();
  end
endmodule : gst_timer_tb_top
